//--- fps_flash_protection_status.sv
// Protection decode, scenario guard and command status flags of the flash controller
// Function
// R1: Polarity high: cleared disable bit protects range
// R2: Polarity low: cleared disable bit opens window
// R3: High size code picks range ending at top
// R4: Low size code picks range from 0x4000
// R5: Setting loaded from array after reset
// R6: Disallowed scenario write leaves register unchanged
// R7: Only listed scenario changes are accepted
// R8: Protection register reads return active scenario
// R9: Normal mode status bit access permissions
// R10: Special mode fail writable, done read-only
// R11: Buffer-empty flag cleared by writing one
// R12: Writing zero mid-sequence aborts, sets access error
// R13: Flag with enable raises interrupt request
// R14: Complete flag clears with buffer-empty, sets last
// R15: Protected target sets violation, blocks launch
// R16: Sequence, illegal command, halt set access error
// R17: Blank set on erased verify, cleared at launch
// R18: Fail set on failed verify, blocks launch
// R19: Done reads zero while operation active
// R20: Size fields writable only while disable set
// R21: Software launches by writing one to buffer-empty
// R22: Flags reset to empty, complete, no errors
// R23: Launch address checked against protected ranges
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module fps_flash_protection_status
  import fps_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Protection setting held in the array
  input wire logic [7:0] i_prot_nv,
  input wire logic i_special_mode,
  // Command sequence events
  input wire logic i_array_wr,
  input wire logic [15:0] i_array_addr,
  input wire logic i_cmd_wr,
  input wire logic i_cmd_legal,
  input wire logic i_cmd_prog_erase,
  input wire logic i_seq_violation,
  input wire logic i_stop_req,
  // Command engine
  input wire logic i_cmd_fetch,
  input wire logic i_cmd_finish,
  input wire logic i_verify_done,
  input wire logic i_verify_blank,
  input wire logic i_op_active,
  output logic o_launch,
  output logic [15:0] o_launch_addr,
  // Interrupt requests
  output logic o_buffer_empty_irq,
  output logic o_complete_irq
);

  fps_state_type s_q;
  fps_state_type s_d;

  function automatic logic in_high(input logic [15:0] a, input logic [1:0] sz);
    logic [15:0] base;
    base = FPS_HIGH_BASE_0;
    unique case (sz)
      2'b00: base = FPS_HIGH_BASE_0;
      2'b01: base = FPS_HIGH_BASE_1;
      2'b10: base = FPS_HIGH_BASE_2;
      2'b11: base = FPS_HIGH_BASE_3;
    endcase
    return a >= base; // R3
  endfunction

  function automatic logic in_low(input logic [15:0] a, input logic [1:0] sz);
    logic [15:0] last;
    last = FPS_LOW_END_0;
    unique case (sz)
      2'b00: last = FPS_LOW_END_0;
      2'b01: last = FPS_LOW_END_1;
      2'b10: last = FPS_LOW_END_2;
      2'b11: last = FPS_LOW_END_3;
    endcase
    return (a >= FPS_LOW_BASE) && (a <= last); // R4
  endfunction

  function automatic logic is_protected(input logic [15:0] a, input logic [7:0] p);
    logic hi;
    logic lo;
    logic hsel;
    logic lsel;
    hi = in_high(a, p[FPS_PROT_HS_LSB +: 2]);
    lo = in_low(a, p[FPS_PROT_LS_LSB +: 2]);
    hsel = !p[FPS_PROT_HDIS_BIT] && hi;
    lsel = !p[FPS_PROT_LDIS_BIT] && lo;
    if (p[FPS_PROT_POL_BIT])
      return hsel || lsel; // R1
    else
      return !(hsel || lsel); // R2
  endfunction

  // Scenario number is the polarity bit over the two disable bits
  function automatic logic [2:0] scenario(input logic [7:0] p);
    return {p[FPS_PROT_POL_BIT], p[FPS_PROT_HDIS_BIT], p[FPS_PROT_LDIS_BIT]};
  endfunction

  function automatic logic allowed(input logic [7:0] from_p, input logic [7:0] to_p);
    return FPS_ALLOW[{scenario(from_p), scenario(to_p)}]; // R7
  endfunction

  // Size fields of a write fall back to the held value while their range is enabled
  function automatic logic [7:0] masked_prot(input logic [7:0] cur, input logic [7:0] w);
    logic [7:0] r;
    r = w;
    if (!cur[FPS_PROT_HDIS_BIT])
      r[FPS_PROT_HS_LSB +: 2] = cur[FPS_PROT_HS_LSB +: 2]; // R20
    if (!cur[FPS_PROT_LDIS_BIT])
      r[FPS_PROT_LS_LSB +: 2] = cur[FPS_PROT_LS_LSB +: 2]; // R20
    return r;
  endfunction

  logic wr_status;
  logic wr_prot;
  logic launch_ok;
  logic [7:0] prot_cand;

  assign wr_status = i_wr && (i_addr == FPS_STATUS_OFS);
  assign wr_prot = i_wr && (i_addr == FPS_PROT_OFS);
  assign prot_cand = masked_prot(s_q.prot, i_wdata);
  assign launch_ok = !s_q.protection_violation_flag && !s_q.access_error_flag && !(i_special_mode && s_q.fail);

  always_comb
  begin
    s_d = s_q;
    s_d.launch = 1'b0;
    s_d.rdata = 8'h00;

    // Protection setting
    if (s_q.load_pend)
    begin
      s_d.prot = i_prot_nv; // R5
      s_d.load_pend = 1'b0;
    end
    else if (wr_prot && allowed(s_q.prot, prot_cand))
      s_d.prot = prot_cand; // R6

    if (i_wr && (i_addr == FPS_CONFIG_OFS))
    begin
      s_d.buffer_empty_irq_enable = i_wdata[FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE_BIT];
      s_d.complete_irq_enable = i_wdata[FPS_CFG_COMPLETE_IRQ_ENABLE_BIT];
    end

    // Clears by software first, so that a hardware set in the same cycle wins
    if (wr_status && i_wdata[FPS_ST_PROTECTION_VIOLATION_FLAG_BIT])
      s_d.protection_violation_flag = 1'b0; // R9
    if (wr_status && i_wdata[FPS_ST_ACCESS_ERROR_FLAG_BIT])
      s_d.access_error_flag = 1'b0; // R9
    if (wr_status && i_special_mode && i_wdata[FPS_ST_FAIL_BIT])
      s_d.fail = 1'b0; // R10

    // Command write sequence
    unique case (s_q.seq)
      FPS_IDLE:
      begin
        if (i_array_wr)
        begin
          s_d.seq = FPS_ADDR;
          s_d.addr = i_array_addr;
        end
      end
      FPS_ADDR:
      begin
        if (wr_status && !i_wdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT])
        begin
          s_d.access_error_flag = 1'b1; // R12
          s_d.seq = FPS_IDLE;
        end
        else if (wr_status || i_array_wr)
        begin
          s_d.access_error_flag = 1'b1; // R16
          s_d.seq = FPS_IDLE;
        end
        else if (i_cmd_wr)
        begin
          if (i_cmd_legal)
            s_d.seq = FPS_CMD;
          else
          begin
            s_d.access_error_flag = 1'b1; // R16
            s_d.seq = FPS_IDLE;
          end
        end
      end
      FPS_CMD:
      begin
        if (wr_status && !i_wdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT])
        begin
          s_d.access_error_flag = 1'b1; // R12
          s_d.seq = FPS_IDLE;
        end
        else if (wr_status && i_wdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT] && launch_ok) // R21
        begin
          s_d.seq = FPS_IDLE;
          if (i_cmd_prog_erase && is_protected(s_q.addr, s_q.prot))
            s_d.protection_violation_flag = 1'b1; // R23
          else
          begin
            s_d.launch = 1'b1; // R15
            s_d.buffer_empty_flag = 1'b0; // R11
            s_d.command_complete_flag = 1'b0; // R14
            s_d.blank = 1'b0; // R17
          end
        end
        else if (i_array_wr || i_cmd_wr)
        begin
          s_d.access_error_flag = 1'b1; // R16
          s_d.seq = FPS_IDLE;
        end
      end
      default:
        s_d.seq = FPS_IDLE;
    endcase

    // Engine events
    if (i_cmd_fetch)
      s_d.buffer_empty_flag = 1'b1;
    // A finish with a command still buffered leaves the complete flag low
    if (i_cmd_finish && s_d.buffer_empty_flag)
      s_d.command_complete_flag = 1'b1; // R14
    if (i_seq_violation || (i_stop_req && !s_q.command_complete_flag))
      s_d.access_error_flag = 1'b1; // R16
    if (i_verify_done && i_verify_blank)
      s_d.blank = 1'b1; // R17
    if (i_verify_done && !i_verify_blank && i_special_mode)
      s_d.fail = 1'b1; // R18
    s_d.done = !i_op_active; // R19

    s_d.irq_be = s_d.buffer_empty_flag && s_d.buffer_empty_irq_enable; // R13
    s_d.irq_cc = s_d.command_complete_flag && s_d.complete_irq_enable; // R13

    // Read data stand only in the cycle after the strobe
    if (i_rd)
    begin
      unique case (i_addr)
        FPS_PROT_OFS:
          s_d.rdata = s_q.prot; // R8
        FPS_CONFIG_OFS:
        begin
          s_d.rdata[FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE_BIT] = s_q.buffer_empty_irq_enable;
          s_d.rdata[FPS_CFG_COMPLETE_IRQ_ENABLE_BIT] = s_q.complete_irq_enable;
        end
        FPS_STATUS_OFS:
        begin
          s_d.rdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT] = s_q.buffer_empty_flag;
          s_d.rdata[FPS_ST_COMMAND_COMPLETE_FLAG_BIT] = s_q.command_complete_flag;
          s_d.rdata[FPS_ST_PROTECTION_VIOLATION_FLAG_BIT] = s_q.protection_violation_flag;
          s_d.rdata[FPS_ST_ACCESS_ERROR_FLAG_BIT] = s_q.access_error_flag;
          s_d.rdata[FPS_ST_BLANK_BIT] = s_q.blank; // R9
          s_d.rdata[FPS_ST_FAIL_BIT] = i_special_mode && s_q.fail; // R10
          s_d.rdata[FPS_ST_DONE_BIT] = i_special_mode && s_q.done; // R10
        end
        default:
          s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.prot <= FPS_PROT_RESET;
      s_q.load_pend <= 1'b1; // R5
      s_q.seq <= FPS_IDLE;
      s_q.buffer_empty_flag <= FPS_BUFFER_EMPTY_FLAG_RESET; // R22
      s_q.command_complete_flag <= FPS_COMMAND_COMPLETE_FLAG_RESET; // R22
      s_q.done <= FPS_DONE_RESET;
    end
    else
      s_q <= s_d;
  end

  assign o_rdata = s_q.rdata;
  assign o_launch = s_q.launch;
  assign o_launch_addr = s_q.addr;
  assign o_buffer_empty_irq = s_q.irq_be;
  assign o_complete_irq = s_q.irq_cc;

  // Checks
  sequence s_launch_write;
    wr_status && i_wdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT] && (s_q.seq == FPS_CMD);
  endsequence

  sequence s_launch_seen;
    s_q.launch && !s_q.buffer_empty_flag && !s_q.command_complete_flag && !s_q.blank;
  endsequence

  a_reset_flags: assert property (@(posedge i_ref_clk) !i_nrst |=> // R22
    (s_q.buffer_empty_flag && s_q.command_complete_flag && !s_q.protection_violation_flag && !s_q.access_error_flag && !s_q.fail && !s_q.blank))
    else $error("flags not at reset values");

  a_launch_effect: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R14
    s_launch_write ##0 (launch_ok && !(i_cmd_prog_erase && is_protected(s_q.addr, s_q.prot))
    && !i_cmd_fetch && !i_verify_done) |=> s_launch_seen)
    else $error("launch did not clear buffer and complete flags");

  a_protection_violation_flag_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R15
    s_q.protection_violation_flag |=> !s_q.launch)
    else $error("launch while protection violation set");

  a_access_error_flag_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R16
    s_q.access_error_flag |=> !s_q.launch)
    else $error("launch while access error set");

  a_protected_refused: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R23
    s_launch_write ##0 (launch_ok && i_cmd_prog_erase && is_protected(s_q.addr, s_q.prot))
    |=> (s_q.protection_violation_flag && !s_q.launch) ##1 !s_q.launch)
    else $error("protected target launched");

  a_prot_guard: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R6
    (wr_prot && !s_q.load_pend && !allowed(s_q.prot, prot_cand)) |=> $stable(s_q.prot))
    else $error("disallowed scenario accepted");

  a_prot_readback: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R8
    (i_rd && i_addr == FPS_PROT_OFS) |=> (o_rdata == $past(s_q.prot)))
    else $error("protection read mismatch");

  a_abort_error: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R12
    (wr_status && !i_wdata[FPS_ST_BUFFER_EMPTY_FLAG_BIT] && s_q.seq != FPS_IDLE) |=> s_q.access_error_flag && s_q.seq == FPS_IDLE)
    else $error("abort did not set access error");

  a_done_tracks: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R19
    i_op_active |=> !s_q.done)
    else $error("done high while operation active");

  a_irq_complete: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R13
    (s_q.command_complete_flag && s_q.complete_irq_enable) |-> o_complete_irq)
    else $error("complete interrupt missing");

  a_fail_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R18
    (i_special_mode && s_q.fail) |=> !s_q.launch)
    else $error("launch while verify failure set");

  a_fetch_empty: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R11
    i_cmd_fetch |=> s_q.buffer_empty_flag)
    else $error("fetch did not set buffer empty");

  a_finish_complete: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R14
    (i_cmd_finish && s_q.buffer_empty_flag && !wr_status) |=> s_q.command_complete_flag)
    else $error("finish did not set complete flag");

  a_pending_held: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R14
    (i_cmd_finish && !s_q.buffer_empty_flag && !i_cmd_fetch) |=> !s_q.command_complete_flag)
    else $error("complete flag set with command pending");

  a_stop_error: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R16
    (i_stop_req && !s_q.command_complete_flag) |=> s_q.access_error_flag)
    else $error("halt during command did not set access error");

  a_verify_blank: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R17
    (i_verify_done && i_verify_blank) |=> s_q.blank)
    else $error("erased verify did not set blank");

  a_verify_fail: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R18
    (i_verify_done && !i_verify_blank && i_special_mode) |=> s_q.fail)
    else $error("failed verify did not set fail");

  a_high_size_locked: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R20
    (wr_prot && !s_q.load_pend && !s_q.prot[FPS_PROT_HDIS_BIT]) |=> $stable(s_q.prot[FPS_PROT_HS_LSB +: 2]))
    else $error("high size changed while range enabled");

  a_low_size_locked: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R20
    (wr_prot && !s_q.load_pend && !s_q.prot[FPS_PROT_LDIS_BIT]) |=> $stable(s_q.prot[FPS_PROT_LS_LSB +: 2]))
    else $error("low size changed while range enabled");

endmodule

//--- fps_pkg.sv
// Package of constants and types for the flash protection and status block
package fps_pkg;

  // Register offsets
  localparam logic [3:0] FPS_CONFIG_OFS = 4'h3;
  localparam logic [3:0] FPS_PROT_OFS = 4'h4;
  localparam logic [3:0] FPS_STATUS_OFS = 4'h5;

  // Protection register fields
  localparam int FPS_PROT_POL_BIT = 7;
  localparam int FPS_PROT_HDIS_BIT = 5;
  localparam int FPS_PROT_HS_LSB = 3;
  localparam int FPS_PROT_LDIS_BIT = 2;
  localparam int FPS_PROT_LS_LSB = 0;

  // Status register fields
  localparam int FPS_ST_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int FPS_ST_COMMAND_COMPLETE_FLAG_BIT = 6;
  localparam int FPS_ST_PROTECTION_VIOLATION_FLAG_BIT = 5;
  localparam int FPS_ST_ACCESS_ERROR_FLAG_BIT = 4;
  localparam int FPS_ST_BLANK_BIT = 2;
  localparam int FPS_ST_FAIL_BIT = 1;
  localparam int FPS_ST_DONE_BIT = 0;

  // Config register fields
  localparam int FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE_BIT = 7;
  localparam int FPS_CFG_COMPLETE_IRQ_ENABLE_BIT = 6;

  // Reset values
  localparam logic [7:0] FPS_PROT_RESET = 8'hff;
  localparam logic FPS_BUFFER_EMPTY_FLAG_RESET = 1'b1;
  localparam logic FPS_COMMAND_COMPLETE_FLAG_RESET = 1'b1;
  localparam logic FPS_DONE_RESET = 1'b1;

  // Range bounds
  localparam logic [15:0] FPS_LOW_BASE = 16'h4000;
  localparam logic [15:0] FPS_LOW_END_0 = 16'h41ff;
  localparam logic [15:0] FPS_LOW_END_1 = 16'h43ff;
  localparam logic [15:0] FPS_LOW_END_2 = 16'h47ff;
  localparam logic [15:0] FPS_LOW_END_3 = 16'h4fff;
  localparam logic [15:0] FPS_HIGH_BASE_0 = 16'hf800;
  localparam logic [15:0] FPS_HIGH_BASE_1 = 16'hf000;
  localparam logic [15:0] FPS_HIGH_BASE_2 = 16'he000;
  localparam logic [15:0] FPS_HIGH_BASE_3 = 16'hc000;

  // Allowed scenario changes, row = from, bit = to
  localparam logic [63:0] FPS_ALLOW = {8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f};

  typedef enum logic [1:0] {
    FPS_IDLE = 2'b00,
    FPS_ADDR = 2'b01,
    FPS_CMD = 2'b10
  } fps_seq_type;

  typedef struct packed {
    logic [7:0] prot;
    logic load_pend;
    fps_seq_type seq;
    logic [15:0] addr;
    logic buffer_empty_flag;
    logic command_complete_flag;
    logic protection_violation_flag;
    logic access_error_flag;
    logic blank;
    logic fail;
    logic done;
    logic buffer_empty_irq_enable;
    logic complete_irq_enable;
    logic [7:0] rdata;
    logic launch;
    logic irq_be;
    logic irq_cc;
  } fps_state_type;

endpackage

//--- fps_flash_protection_status_test.sv
// Self-checking testbench for the flash protection and status block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module fps_flash_protection_status_test;
  import fps_pkg::*;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_special_mode = 1'b0, i_array_wr = 1'b0;
  logic i_cmd_wr = 1'b0, i_cmd_legal = 1'b0, i_cmd_prog_erase = 1'b0, i_verify_blank = 1'b0, i_op_active = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, i_prot_nv = 8'hff, o_rdata, rv, prot_m, nv, d;
  logic [15:0] i_array_addr = 16'h0000, o_launch_addr, a;
  logic o_launch, o_buffer_empty_irq, o_complete_irq;
  int fails = 0, total_checks = 0, hb, le;
  bit buffer_empty_flag, command_complete_flag, protection_violation_flag, access_error_flag, blank, fail, buffer_empty_irq_enable, complete_irq_enable;
  bit [7:0] allow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  fps_flash_protection_status dut_u (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_prot_nv(i_prot_nv), .i_special_mode(i_special_mode), .i_array_wr(i_array_wr),
    .i_array_addr(i_array_addr), .i_cmd_wr(i_cmd_wr), .i_cmd_legal(i_cmd_legal),
    .i_cmd_prog_erase(i_cmd_prog_erase), .i_seq_violation(ev[3]), .i_stop_req(ev[4]), .i_cmd_fetch(ev[0]),
    .i_cmd_finish(ev[1]), .i_verify_done(ev[2]), .i_verify_blank(i_verify_blank), .i_op_active(i_op_active),
    .o_launch(o_launch), .o_launch_addr(o_launch_addr), .o_buffer_empty_irq(o_buffer_empty_irq),
    .o_complete_irq(o_complete_irq));

  initial forever #2 i_ref_clk = ~i_ref_clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    fails++;
    finish_test;
  end

  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= dt;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask

  // Bits: 0 fetch, 1 finish, 2 verify done, 3 sequence violation, 4 halt
  task automatic pulse(input logic [4:0] m);
    @(posedge i_ref_clk);
    ev <= m;
    @(posedge i_ref_clk);
    ev <= 5'h00;
    #1;
  endtask

  task automatic chk_st;
    rd(FPS_STATUS_OFS);
    `CHK(rv, {buffer_empty_flag, command_complete_flag, protection_violation_flag, access_error_flag, 1'b0, blank, i_special_mode & fail, i_special_mode & ~i_op_active})
    `CHK({o_buffer_empty_irq, o_complete_irq}, {buffer_empty_flag & buffer_empty_irq_enable, command_complete_flag & complete_irq_enable})
  endtask

  task automatic do_reset(input logic [7:0] v);
    i_nrst <= 1'b0;
    i_prot_nv <= v;
    repeat (16) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    prot_m = v;
    {buffer_empty_flag, command_complete_flag, protection_violation_flag, access_error_flag, blank, fail, buffer_empty_irq_enable, complete_irq_enable} = 8'hc0;
  endtask

  function automatic bit prot_f(logic [7:0] p, int ad);
    bit w;
    w = (!p[5] && ad >= 'h10000 - ('h800 << p[4:3])) || (!p[2] && ad >= 'h4000 && ad < 'h4000 + ('h200 << p[1:0]));
    return p[7] ? w : !w;
  endfunction

  // Size fields follow the disable bits currently in force
  task automatic wr_prot(input logic [7:0] v);
    logic [7:0] n;
    n = v;
    wr(FPS_PROT_OFS, v);
    if (allow[{prot_m[7], prot_m[5], prot_m[2]}][{v[7], v[5], v[2]}])
    begin
      if (!prot_m[5]) n[4:3] = prot_m[4:3];
      if (!prot_m[2]) n[1:0] = prot_m[1:0];
      prot_m = n;
    end
  endtask

  task automatic launch(input logic [15:0] ad, input bit pe, input bit lg, input bit fin);
    bit exp_l;
    bit blk;
    @(posedge i_ref_clk);
    i_array_wr <= 1'b1;
    i_array_addr <= ad;
    @(posedge i_ref_clk);
    i_array_wr <= 1'b0;
    i_cmd_wr <= 1'b1;
    i_cmd_legal <= lg;
    i_cmd_prog_erase <= pe;
    @(posedge i_ref_clk);
    i_cmd_wr <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= FPS_STATUS_OFS;
    i_wdata <= 8'h80;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
    blk = protection_violation_flag || access_error_flag || (i_special_mode && fail);
    exp_l = lg && !blk && !(pe && prot_f(prot_m, ad));
    `CHK(o_launch, exp_l)
    if (!lg)
      access_error_flag = 1'b1;
    else if (!blk && !exp_l)
      protection_violation_flag = 1'b1;
    if (exp_l)
    begin
      `CHK(o_launch_addr, ad)
      {buffer_empty_flag, command_complete_flag, blank} = 3'b000;
    end
    chk_st;
    if (exp_l && fin)
    begin
      pulse(5'h01);
      pulse(5'h02);
      {buffer_empty_flag, command_complete_flag} = 2'b11;
    end
  endtask

  initial
  begin
    void'($urandom(51));
    do_reset(8'hff);
    chk_st;
    rd(FPS_PROT_OFS);
    `CHK(rv, 8'hff)
    rd(4'h9);
    `CHK(rv, 8'h00)
    wr(FPS_CONFIG_OFS, 8'hc0);
    {buffer_empty_irq_enable, complete_irq_enable} = 2'b11;
    rd(FPS_CONFIG_OFS);
    `CHK(rv, 8'hc0)
    chk_st;
    $display("test reset done");
    for (int i = 0; i < 48; i++)
    begin
      nv = $urandom;
      nv[6] = 1'b1;
      if (i < 8) {nv[7], nv[5], nv[2]} = 3'(i);
      do_reset(nv);
      rd(FPS_PROT_OFS);
      `CHK(rv, prot_m)
      d = $urandom;
      d[6] = 1'b1;
      wr_prot(d);
      rd(FPS_PROT_OFS);
      `CHK(rv, prot_m)
      hb = 'h10000 - ('h800 << prot_m[4:3]);
      le = 'h4000 + ('h200 << prot_m[1:0]);
      repeat (4)
      begin
        case ($urandom % 7)
          0: a = 16'(hb);
          1: a = 16'(hb - 1);
          2: a = 16'h4000;
          3: a = 16'h3fff;
          4: a = 16'(le - 1);
          5: a = 16'(le);
          default: a = 16'($urandom);
        endcase
        launch(a, $urandom % 4 != 0, 1'b1, 1'b1);
        if (protection_violation_flag)
        begin
          wr(FPS_STATUS_OFS, 8'h20);
          protection_violation_flag = 1'b0;
        end
      end
      chk_st;
    end
    $display("test protection done");
    do_reset(8'hff);
    @(posedge i_ref_clk);
    i_array_wr <= 1'b1;
    i_array_addr <= 16'h8000;
    @(posedge i_ref_clk);
    i_array_wr <= 1'b0;
    wr(FPS_STATUS_OFS, 8'h00);
    access_error_flag = 1'b1;
    chk_st;
    wr(FPS_STATUS_OFS, 8'h30);
    access_error_flag = 1'b0;
    wr(FPS_STATUS_OFS, 8'h00);
    chk_st;
    launch(16'h8000, 1'b1, 1'b0, 1'b1);
    launch(16'h8000, 1'b1, 1'b1, 1'b1);
    // A launch refused for the set access error leaves the sequence open, so abort it before clearing
    wr(FPS_STATUS_OFS, 8'h00);
    wr(FPS_STATUS_OFS, 8'h10);
    access_error_flag = 1'b0;
    launch(16'h9000, 1'b1, 1'b1, 1'b0);
    pulse(5'h02);
    chk_st;
    pulse(5'h10);
    access_error_flag = 1'b1;
    pulse(5'h01);
    buffer_empty_flag = 1'b1;
    chk_st;
    pulse(5'h02);
    command_complete_flag = 1'b1;
    wr(FPS_STATUS_OFS, 8'h10);
    access_error_flag = 1'b0;
    pulse(5'h08);
    access_error_flag = 1'b1;
    chk_st;
    wr(FPS_STATUS_OFS, 8'h10);
    access_error_flag = 1'b0;
    $display("test errors done");
    i_special_mode <= 1'b1;
    pulse(5'h04);
    fail = 1'b1;
    chk_st;
    launch(16'h8000, 1'b0, 1'b1, 1'b1);
    wr(FPS_STATUS_OFS, 8'h00);
    wr(FPS_STATUS_OFS, 8'h12);
    fail = 1'b0;
    chk_st;
    i_verify_blank <= 1'b1;
    pulse(5'h04);
    blank = 1'b1;
    i_op_active <= 1'b1;
    chk_st;
    i_op_active <= 1'b0;
    launch(16'h8000, 1'b0, 1'b1, 1'b1);
    $display("test special done");
    finish_test;
  end
endmodule
